// ==== verilog/sfr_reset_defines.svh ====
// Offsets, reset values and field positions of the reset-dependent register bank
`ifndef SFR_RESET_DEFINES_SVH
`define SFR_RESET_DEFINES_SVH
`define OFS_RC_TUNE 8'h96
`define OFS_WDOG_CONTROL 8'hA7
`define OFS_WDOG_LOAD 8'hC1
`define OFS_WDOG_FEED_FIRST 8'hC2
`define OFS_RESET_CAUSE 8'hDF
`define OFS_BAUD_CONTROL 8'hBD
`define OFS_BAUD_LOW 8'hBE
`define OFS_BAUD_HIGH 8'hBF
`define OFS_PORT_DIR 8'hB0
`define OFS_IRQ_STATUS 8'hE0
`define OFS_IRQ_ENABLE 8'hE1
`define OFS_IRQ_CLEAR 8'hE2
`define WDOG_CTRL_RST 8'hE5
`define WDOG_TOF_BIT 1
`define RESET_CAUSE_POR 8'h30
`define RESET_CAUSE_IMPL 8'h3F
`define RC_TUNE_FACTORY 8'h20
`define WDOG_LOAD_RST 8'hFF
`define BIT_POF 5
`define BIT_BOF 4
`define BIT_WDT_SRC 3
`define BIT_EXT_SRC 2
`define BIT_SW_SRC 1
`define BIT_OTHER_SRC 0
`define BIT_CLK_OUT_EN 6
`define BIT_BAUD_ON 0
`define UNIMPL_FILL 8'h00
`define IRQ_BAUD_VIOL 0
`define IRQ_BAUD_FED 1
`endif

// ==== verilog/sfr_reset_pkg.sv ====
// Types shared by the reset-dependent register bank
package sfr_reset_pkg;
    typedef enum logic [2:0] {
        RST_NONE,
        RST_POWER_ON,
        RST_BROWNOUT,
        RST_WATCHDOG,
        RST_EXTERNAL,
        RST_SOFTWARE
    } reset_kind_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sfr_req_t;
    typedef struct packed {
        logic rc_clock_ctrl;
        logic clock_out_en;
        logic [5:0] trim;
    } rc_tune_t;
endpackage

// ==== verilog/sync_two_ff.sv ====
// Two-flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Level in and out
    input wire logic din,
    output logic dout
);
    logic meta_q;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/sfr_reset_init_bank.sv ====
// Reset-dependent special function register bank with reset cause and clock output
// How it works
// - Unimplemented bits of reset cause and baud control read back as unknown, others as zero
// - Port pins input-only after power-up
// - Power-up leaves reset cause xx11 0000
// - Watchdog control resets to 1110 01x1
// - Timeout flag: watchdog sets, power-on clears
// - Only power-on loads factory trim value
// - Trim register: rc clock, clkout, trim
// - Clock out enable drives half rate clock unless the crystal is in use
// - Trim field writes retune the oscillator
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_reset_defines.svh"
module sfr_reset_init_bank (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Kind of the reset now held on srst
    input wire sfr_reset_pkg::reset_kind_t reset_kind,
    input wire logic xtal_in_use,
    // Register port
    input wire sfr_reset_pkg::sfr_req_t req,
    output logic [7:0] rdata,
    // Oscillator control
    output logic [5:0] rc_trim,
    output logic rc_clock_ctrl,
    // Crystal output pin
    input wire logic xtal2_pin_in,
    output logic xtal2_out,
    output logic xtal2_oe_n,
    // Watchdog control outputs
    output logic wdog_run,
    output logic wdog_clock_sel,
    output logic [2:0] wdog_prescale_sel,
    // Interrupt
    output logic irq
);
    import sfr_reset_pkg::*;

    logic [7:0] reset_cause_q;
    logic [7:0] wdog_ctrl_q;
    logic [7:0] wdog_load_q;
    rc_tune_t rc_tune_q;
    logic [7:0] baud_ctrl_q;
    logic [7:0] baud_low_q;
    logic [7:0] baud_high_q;
    logic port_dir_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_enable_q;
    logic [7:0] rdata_q;
    logic clk_div_q;
    logic xtal2_out_q;
    logic xtal2_oe_n_q;
    logic irq_q;
    logic pin_sync;
    logic wr_baud_div;
    logic baud_viol;
    logic baud_fed;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;

    sync_two_ff u_pin_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .din(xtal2_pin_in),
        .dout(pin_sync)
    );

    assign wr_baud_div = req.wr && (req.addr == `OFS_BAUD_LOW || req.addr == `OFS_BAUD_HIGH);
    assign baud_viol = wr_baud_div && baud_ctrl_q[`BIT_BAUD_ON];
    assign baud_fed = wr_baud_div && !baud_ctrl_q[`BIT_BAUD_ON];

    // Reset cause: power-up clears all but the power flags
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            case (reset_kind)
                RST_POWER_ON: reset_cause_q <= `RESET_CAUSE_POR;
                RST_BROWNOUT: reset_cause_q <= reset_cause_q | 8'h10;
                RST_WATCHDOG: reset_cause_q <= (reset_cause_q & 8'h30) | 8'h08;
                RST_EXTERNAL: reset_cause_q <= (reset_cause_q & 8'h30) | 8'h04;
                RST_SOFTWARE: reset_cause_q <= (reset_cause_q & 8'h30) | 8'h02;
                default: reset_cause_q <= (reset_cause_q & 8'h30) | 8'h01;
            endcase
        end else if (req.wr && req.addr == `OFS_RESET_CAUSE) begin
            reset_cause_q <= reset_cause_q & req.wdata & `RESET_CAUSE_IMPL;
        end
    end

    // Watchdog control and load
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wdog_ctrl_q[7:2] <= 6'(`WDOG_CTRL_RST >> 2);
            wdog_ctrl_q[0] <= 1'b1;
            if (reset_kind == RST_WATCHDOG) begin
                wdog_ctrl_q[`WDOG_TOF_BIT] <= 1'b1;
            end else if (reset_kind == RST_POWER_ON) begin
                wdog_ctrl_q[`WDOG_TOF_BIT] <= 1'b0;
            end
            wdog_load_q <= `WDOG_LOAD_RST;
        end else begin
            if (req.wr && req.addr == `OFS_WDOG_CONTROL) begin
                wdog_ctrl_q <= req.wdata;
            end
            if (req.wr && req.addr == `OFS_WDOG_LOAD) begin
                wdog_load_q <= req.wdata;
            end
        end
    end

    // Trim register only loaded from factory on power-on
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            if (reset_kind == RST_POWER_ON) begin
                rc_tune_q <= `RC_TUNE_FACTORY;
            end
        end else if (req.wr && req.addr == `OFS_RC_TUNE) begin
            rc_tune_q <= req.wdata;
        end
    end

    // Baud generator control and divisors
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            baud_ctrl_q <= 8'h00;
            baud_low_q <= 8'h00;
            baud_high_q <= 8'h00;
        end else begin
            if (req.wr && req.addr == `OFS_BAUD_CONTROL) begin
                baud_ctrl_q <= req.wdata & 8'h01;
            end
            if (baud_fed && req.addr == `OFS_BAUD_LOW) begin
                baud_low_q <= req.wdata;
            end
            if (baud_fed && req.addr == `OFS_BAUD_HIGH) begin
                baud_high_q <= req.wdata;
            end
        end
    end

    // Port direction: input-only after power-up
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            if (reset_kind == RST_POWER_ON) begin
                port_dir_q <= 1'b0;
            end
        end else if (req.wr && req.addr == `OFS_PORT_DIR) begin
            port_dir_q <= req.wdata[0];
        end
    end

    // Interrupt status: set wins over clear
    assign irq_set = {baud_fed, baud_viol};
    assign irq_clr = (req.wr && req.addr == `OFS_IRQ_CLEAR) ? req.wdata[1:0] : 2'h0;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_status_q <= 2'h0;
            irq_enable_q <= 2'h0;
            irq_q <= 1'b0;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
            if (req.wr && req.addr == `OFS_IRQ_ENABLE) begin
                irq_enable_q <= req.wdata[1:0];
            end
            irq_q <= |(((irq_status_q & ~irq_clr) | irq_set) & irq_enable_q);
        end
    end

    // Clock output at half the system rate on the crystal pin
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clk_div_q <= 1'b0;
            xtal2_out_q <= 1'b0;
            xtal2_oe_n_q <= 1'b1;
        end else begin
            clk_div_q <= ~clk_div_q;
            if (rc_tune_q.clock_out_en && !xtal_in_use) begin
                xtal2_out_q <= clk_div_q;
                xtal2_oe_n_q <= 1'b0;
            end else begin
                xtal2_out_q <= 1'b0;
                xtal2_oe_n_q <= ~port_dir_q;
            end
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `OFS_RC_TUNE: rdata_q <= rc_tune_q;
                `OFS_WDOG_CONTROL: rdata_q <= wdog_ctrl_q;
                `OFS_WDOG_LOAD: rdata_q <= wdog_load_q;
                `OFS_RESET_CAUSE: rdata_q <= {2'bxx, reset_cause_q[5:0]};
                `OFS_BAUD_CONTROL: rdata_q <= {7'bxxxxxxx, baud_ctrl_q[0]};
                `OFS_BAUD_LOW: rdata_q <= baud_low_q;
                `OFS_BAUD_HIGH: rdata_q <= baud_high_q;
                `OFS_PORT_DIR: rdata_q <= {6'h00, pin_sync, port_dir_q};
                `OFS_IRQ_STATUS: rdata_q <= {6'h00, irq_status_q};
                `OFS_IRQ_ENABLE: rdata_q <= {6'h00, irq_enable_q};
                default: rdata_q <= `UNIMPL_FILL;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata = rdata_q;
    assign rc_trim = rc_tune_q.trim;
    assign rc_clock_ctrl = rc_tune_q.rc_clock_ctrl;
    assign xtal2_out = xtal2_out_q;
    assign xtal2_oe_n = xtal2_oe_n_q;
    assign wdog_run = wdog_ctrl_q[2];
    assign wdog_clock_sel = wdog_ctrl_q[0];
    assign wdog_prescale_sel = wdog_ctrl_q[7:5];
    assign irq = irq_q;

    // Reset values
    chk_por_cause: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_POWER_ON) |=> reset_cause_q == `RESET_CAUSE_POR)
        else $error("reset cause wrong after power-on");
    chk_wdog_reset_val: assert property (@(posedge clk_sys)
        srst |=> (wdog_ctrl_q & 8'hFD) == `WDOG_CTRL_RST)
        else $error("watchdog control reset value wrong");
    chk_wdog_fields: assert property (@(posedge clk_sys)
        srst |=> wdog_prescale_sel == 3'h7 && wdog_run && wdog_clock_sel)
        else $error("watchdog control outputs wrong after reset");
    chk_tof_watchdog: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_WATCHDOG) |=> wdog_ctrl_q[`WDOG_TOF_BIT])
        else $error("timeout flag not set by watchdog reset");
    chk_tof_por: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_POWER_ON) |=> !wdog_ctrl_q[`WDOG_TOF_BIT])
        else $error("timeout flag not cleared by power-on reset");
    chk_tof_other: assert property (@(posedge clk_sys)
        (srst && reset_kind != RST_POWER_ON && reset_kind != RST_WATCHDOG) |=> $stable(wdog_ctrl_q[`WDOG_TOF_BIT]))
        else $error("timeout flag disturbed by other reset");
    chk_trim_factory: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_POWER_ON) |=> rc_tune_q == `RC_TUNE_FACTORY)
        else $error("trim not loaded by power-on reset");
    chk_trim_kept: assert property (@(posedge clk_sys)
        (srst && reset_kind != RST_POWER_ON) |=> $stable(rc_tune_q))
        else $error("trim changed by non power-on reset");
    chk_pin_input: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_POWER_ON) |=> ##1 xtal2_oe_n)
        else $error("pin driven after power-up");
    chk_port_por: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_POWER_ON) |=> !port_dir_q)
        else $error("port drive left on after power-up");

    // Reset cause history
    chk_cause_keep: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_SOFTWARE) |=> reset_cause_q[5:4] == $past(reset_cause_q[5:4]))
        else $error("power flags disturbed");
    chk_cause_wdog: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_WATCHDOG) |=> reset_cause_q[3:0] == 4'h8)
        else $error("watchdog source not recorded");
    chk_cause_ext: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_EXTERNAL) |=> reset_cause_q[3:0] == 4'h4)
        else $error("external source not recorded");
    chk_cause_soft: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_SOFTWARE) |=> reset_cause_q[3:0] == 4'h2)
        else $error("software source not recorded");
    chk_cause_other: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_NONE) |=> reset_cause_q[3:0] == 4'h1)
        else $error("other source not recorded");
    chk_cause_brownout: assert property (@(posedge clk_sys)
        (srst && reset_kind == RST_BROWNOUT) |=> reset_cause_q[`BIT_BOF] && reset_cause_q[3:0] == $past(reset_cause_q[3:0]))
        else $error("brownout source not recorded");

    // Register port
    chk_trim_write: assert property (@(posedge clk_sys) disable iff (srst)
        (req.wr && req.addr == `OFS_RC_TUNE) |=> rc_trim == $past(req.wdata[5:0]))
        else $error("trim write not taken");
    chk_trim_read: assert property (@(posedge clk_sys) disable iff (srst)
        (req.rd && req.addr == `OFS_RC_TUNE) |=> rdata == $past(rc_tune_q) && rc_clock_ctrl == rdata[7] && rc_trim == rdata[5:0])
        else $error("trim register fields out of place");
    chk_baud_held: assert property (@(posedge clk_sys) disable iff (srst)
        baud_viol |=> $stable(baud_low_q) && $stable(baud_high_q))
        else $error("baud divisor changed while generator on");
    chk_baud_written: assert property (@(posedge clk_sys) disable iff (srst)
        (baud_fed && req.addr == `OFS_BAUD_LOW) |=> baud_low_q == $past(req.wdata))
        else $error("baud divisor write not taken");
    chk_baud_viol_flag: assert property (@(posedge clk_sys) disable iff (srst)
        baud_viol |=> irq_status_q[`IRQ_BAUD_VIOL])
        else $error("dropped baud write not flagged");
    chk_irq_set_wins: assert property (@(posedge clk_sys) disable iff (srst)
        (irq_set != 2'h0) |=> (irq_status_q & $past(irq_set)) == $past(irq_set))
        else $error("status event lost to clear");
    chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (srst)
        !req.rd |=> rdata == 8'h00)
        else $error("read data not zero without read");

    // Clock output
    chk_clkout_toggle: assert property (@(posedge clk_sys) disable iff (srst)
        (rc_tune_q.clock_out_en && !xtal_in_use && $past(rc_tune_q.clock_out_en && !xtal_in_use) && !$past(srst))
        |=> xtal2_out != $past(xtal2_out))
        else $error("clock out not toggling");
    chk_clkout_drive: assert property (@(posedge clk_sys) disable iff (srst)
        (rc_tune_q.clock_out_en && !xtal_in_use) |=> !xtal2_oe_n)
        else $error("clock out pin not driven");
    chk_clkout_blocked: assert property (@(posedge clk_sys) disable iff (srst)
        xtal_in_use |=> !xtal2_out)
        else $error("clock out active while crystal in use");
endmodule
`default_nettype wire

// ==== testbench/sfr_reset_init_bank_bench.sv ====
// Self-checking bench for the reset-dependent register bank
`timescale 1ns/1ps
`default_nettype none
`include "sfr_reset_defines.svh"
module sfr_reset_init_bank_bench;
    import sfr_reset_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] m; logic [7:0] e;} row_t;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    reset_kind_t reset_kind = RST_POWER_ON;
    logic xtal_in_use = 1'b1;
    sfr_req_t req = '0;
    logic xtal2_pin_in = 1'b0;
    logic [7:0] rdata;
    logic [5:0] rc_trim;
    logic rc_clock_ctrl;
    logic xtal2_out;
    logic xtal2_oe_n;
    logic wdog_run;
    logic wdog_clock_sel;
    logic [2:0] wdog_prescale_sel;
    logic irq;
    int num_errors = 0;
    int tests_run = 0;
    logic [7:0] rv;
    logic s0;
    // Plain write then read-back cases: address, data, mask of implemented bits, expected read
    row_t rows [6] = '{'{8'h96, 8'hDA, 8'hFF, 8'hDA}, '{8'hC1, 8'h3C, 8'hFF, 8'h3C},
        '{8'hBE, 8'h11, 8'hFF, 8'h11}, '{8'hBF, 8'h22, 8'hFF, 8'h22},
        '{8'hBD, 8'h00, 8'h01, 8'h00}, '{8'h10, 8'hAA, 8'hFF, 8'h00}};
    reset_kind_t kinds [4] = '{RST_WATCHDOG, RST_EXTERNAL, RST_SOFTWARE, RST_NONE};
    logic [7:0] causes [4] = '{8'h38, 8'h34, 8'h32, 8'h31};

    sfr_reset_init_bank DUT (.clk_sys(clk_sys), .srst(srst), .reset_kind(reset_kind),
        .xtal_in_use(xtal_in_use), .req(req), .rdata(rdata), .rc_trim(rc_trim),
        .rc_clock_ctrl(rc_clock_ctrl), .xtal2_pin_in(xtal2_pin_in), .xtal2_out(xtal2_out),
        .xtal2_oe_n(xtal2_oe_n), .wdog_run(wdog_run), .wdog_clock_sel(wdog_clock_sel),
        .wdog_prescale_sel(wdog_prescale_sel), .irq(irq));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        @(posedge clk_sys);
        rv = rdata;
    endtask

    task automatic do_reset(input reset_kind_t k);
        @(posedge clk_sys);
        srst <= 1'b1;
        reset_kind <= k;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic por_checks;
        do_reset(RST_POWER_ON);
        rd(8'hDF);
        check("cause", rv & 8'h3F, 8'h30);
        check("cause_unimpl", {rv[7:6], 6'h00}, {2'hX, 6'h00});
        rd(8'hA7);
        check("wdog_ctrl", rv, 8'hE5);
        check("wdog_fields", {3'h0, wdog_prescale_sel, wdog_run, wdog_clock_sel}, 8'h1F);
        check("trim", {rc_clock_ctrl, 1'b0, rc_trim}, 8'h20);
        rd(8'hB0);
        check("port_drive", rv & 8'h01, 8'h00);
        check("oe_n", {7'h00, xtal2_oe_n}, 8'h01);
        $display("test power-on done");
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        por_checks();
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            check("row", rv & rows[i].m, rows[i].e);
        end
        check("rc_trim", {rc_clock_ctrl, 1'b0, rc_trim}, 8'h9A);
        $display("test table done");
        xtal_in_use <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 s0 = xtal2_out;
        @(posedge clk_sys);
        #1 check("clkout", {7'h00, xtal2_out}, {7'h00, ~s0});
        check("clkout_oe", {7'h00, xtal2_oe_n}, 8'h00);
        wr(8'h96, 8'h1A);
        repeat (2) @(posedge clk_sys);
        #1 check("clkout_off", {7'h00, xtal2_oe_n}, 8'h01);
        $display("test clock out done");
        wr(8'hE2, 8'h03);
        wr(8'hE1, 8'h03);
        wr(8'hBD, 8'h01);
        wr(8'hBE, 8'h77);
        rd(8'hBE);
        check("baud_drop", rv, 8'h11);
        check("irq_on", {7'h00, irq}, 8'h01);
        rd(8'hE0);
        check("status", rv & 8'h03, 8'h01);
        wr(8'hE2, 8'h01);
        rd(8'hE0);
        check("status_clr", rv & 8'h03, 8'h00);
        check("irq_off", {7'h00, irq}, 8'h00);
        wr(8'hBD, 8'h00);
        wr(8'hBE, 8'h44);
        rd(8'hBE);
        check("baud_ok", rv, 8'h44);
        check("irq_fed", {7'h00, irq}, 8'h01);
        wr(8'hE1, 8'h01);
        rd(8'hE0);
        check("status_fed", rv & 8'h03, 8'h02);
        check("irq_mask", {7'h00, irq}, 8'h00);
        wr(8'hE2, 8'h02);
        $display("test interrupt done");
        xtal2_pin_in <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(8'hB0);
        check("pin_level", rv & 8'h02, 8'h02);
        wr(8'hB0, 8'h01);
        repeat (2) @(posedge clk_sys);
        check("port_on", {7'h00, xtal2_oe_n}, 8'h00);
        $display("test pin done");
        foreach (kinds[i]) begin
            do_reset(kinds[i]);
            rd(8'hDF);
            check("cause_kind", rv & 8'h3F, causes[i]);
            rd(8'hA7);
            check("wdog_tof", rv, 8'hE7);
            check("trim_kept", {2'h0, rc_trim}, 8'h1A);
        end
        wr(8'hDF, 8'h00);
        rd(8'hDF);
        check("cause_clear", rv & 8'h3F, 8'h00);
        do_reset(RST_BROWNOUT);
        rd(8'hDF);
        check("cause_bo", rv & 8'h3F, 8'h10);
        $display("test reset kinds done");
        por_checks();
        give_verdict();
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
